// ==== hdl/core_exec.v ====
// Execution core for a small set of 8-bit instructions, driven from
// an AXI4-Lite command register, with accumulator, status, program
// counter, config, stack top and a 32-byte file register window.
// Assumes a single clock aclk and a synchronous active-low reset.
//
// How it works
// - jump loads nine-bit operand into low counter
// - jump fills counter bits 10:9 from page
// - jump takes two cycles, flags untouched
// - literal OR into accumulator, zero updated
// - OR accumulator with file register, zero updated
// - destination bit picks accumulator or file
// - store accumulator to file, flags untouched
// - move file to destination, zero updated
// - load literal into accumulator, flags untouched
// - accumulator copied into config, flags untouched
// - return loads literal, counter from stack top
// - return takes two cycles, fetch discarded
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`include "core_exec_consts.vh"

module core_exec #(
	parameter FILE_DEPTH = 32
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [10:0] pc_out,
	output reg  [7:0]  config_out
);

	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam ST_IDLE  = 3'b001;
	localparam ST_EXEC  = 3'b010;
	localparam ST_FLUSH = 3'b100;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	reg  [2:0]  state_r;
	reg  [7:0]  acc_r;
	reg  [7:0]  status_r;
	reg  [10:0] pc_r;
	reg  [7:0]  config_r;
	reg  [10:0] stack_r;
	reg  [3:0]  op_r;
	reg         dest_r;
	reg  [4:0]  fsel_r;
	reg  [8:0]  k_r;
	reg         bad_op_r;
	reg  [1:0]  last_cyc_r;
	reg  [7:0]  file_mem [0:FILE_DEPTH-1];
	reg  [7:0]  aw_addr_r;
	reg         aw_full_r;
	reg  [31:0] w_data_r;
	reg  [3:0]  w_strb_r;
	reg         w_full_r;
	reg  [31:0] rdata_nxt;
	reg  [1:0]  rresp_nxt;
	reg         wr_ok;
	reg  [7:0]  alu_a;
	reg  [7:0]  alu_b;
	wire [7:0]  alu_res;
	wire        alu_zero;
	wire [7:0]  file_sel;
	wire [10:0] pc_inc;
	wire        do_write;
	wire        in_file;
	integer     i;

	assign file_sel = file_mem[fsel_r];
	assign pc_inc   = pc_r + 11'h001;
	assign in_file  = aw_addr_r[`FILE_WIN_BIT];
	// Writes wait while an instruction runs so that software and the
	// core never update the same register in one cycle
	assign do_write = aw_full_r && w_full_r && !s_axi_bvalid && (state_r == ST_IDLE);

	// ----------------------------------------------------------------
	// Result path
	// ----------------------------------------------------------------
	// Operands: accumulator takes part only in the OR forms
	always @* begin
		alu_a = 8'h00;
		alu_b = file_sel;
		case (op_r)
			`OP_OR_LIT: begin
				alu_a = acc_r;
				alu_b = k_r[7:0];
			end
			`OP_OR_FILE: begin
				alu_a = acc_r;
			end
			default: begin
				alu_a = 8'h00;
			end
		endcase
	end

	result_unit #(
		.W      (8)
	) u_result (
		.a      (alu_a),
		.b      (alu_b),
		.result (alu_res),
		.zero   (alu_zero)
	);

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	// Command words must come whole; partial strobes are refused
	always @* begin
		wr_ok = 1'b1;
		if (!in_file) begin
			case (aw_addr_r)
				`OFS_CMD:    wr_ok = (w_strb_r == 4'hF);
				`OFS_ACC:    wr_ok = 1'b1;
				`OFS_STATUS: wr_ok = 1'b1;
				`OFS_PC:     wr_ok = 1'b1;
				`OFS_STACK:  wr_ok = 1'b1;
				`OFS_STATE:  wr_ok = 1'b1;
				default:     wr_ok = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Write channels
	// ----------------------------------------------------------------
	// Address and data are held apart, so either may arrive first
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			aw_full_r     <= 1'b0;
			w_full_r      <= 1'b0;
			aw_addr_r     <= 8'h00;
			w_data_r      <= 32'h0000_0000;
			w_strb_r      <= 4'h0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_r     <= s_axi_awaddr;
				aw_full_r     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_r     <= s_axi_wdata;
				w_strb_r     <= s_axi_wstrb;
				w_full_r     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_full_r     <= 1'b0;
				w_full_r      <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
				s_axi_bvalid  <= 1'b1;
				s_axi_bresp   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	// Read data is a snapshot taken at the address handshake
	always @* begin
		rdata_nxt = 32'h0000_0000;
		rresp_nxt = `RESP_OKAY;
		if (s_axi_araddr[`FILE_WIN_BIT]) begin
			rdata_nxt = {24'h00_0000, file_mem[s_axi_araddr[6:2]]};
		end else begin
			case (s_axi_araddr)
				`OFS_CMD:    rdata_nxt = {7'h00, k_r, 3'h0, fsel_r, 3'h0, dest_r, op_r};
				`OFS_ACC:    rdata_nxt = {24'h00_0000, acc_r};
				`OFS_STATUS: rdata_nxt = {24'h00_0000, status_r};
				`OFS_PC:     rdata_nxt = {21'h00_0000, pc_r};
				`OFS_CONFIG: rdata_nxt = {24'h00_0000, config_r};
				`OFS_STACK:  rdata_nxt = {21'h00_0000, stack_r};
				`OFS_STATE:  rdata_nxt = {26'h000_0000, last_cyc_r, 1'b0, bad_op_r,
					1'b0, (state_r != ST_IDLE)};
				default:     rresp_nxt = `RESP_SLVERR;
			endcase
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rdata_nxt;
			s_axi_rresp   <= rresp_nxt;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Core state and execution
	// ----------------------------------------------------------------
	// Software writes land only in idle, execution only in its own
	// states, so the two never collide on one register
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_r    <= ST_IDLE;
			acc_r      <= `RST_ACC;
			status_r   <= `RST_STATUS;
			pc_r       <= `RST_PC;
			config_r   <= `RST_CONFIG;
			stack_r    <= `RST_STACK;
			op_r       <= `OP_IDLE;
			dest_r     <= 1'b0;
			fsel_r     <= 5'h00;
			k_r        <= 9'h000;
			bad_op_r   <= 1'b0;
			last_cyc_r <= 2'h0;
			pc_out     <= `RST_PC;
			config_out <= `RST_CONFIG;
			for (i = 0; i < FILE_DEPTH; i = i + 1) begin
				file_mem[i] <= 8'h00;
			end
		end else begin
			pc_out     <= pc_r;
			config_out <= config_r;
			case (state_r)
				ST_IDLE: begin
					if (do_write && wr_ok) begin
						if (in_file) begin
							if (w_strb_r[0]) file_mem[aw_addr_r[6:2]] <= w_data_r[7:0];
						end else begin
							case (aw_addr_r)
								`OFS_CMD: begin
									op_r    <= w_data_r[`CMD_OP_MSB:`CMD_OP_LSB];
									dest_r  <= w_data_r[`CMD_DEST_BIT];
									fsel_r  <= w_data_r[`CMD_FILE_MSB:`CMD_FILE_LSB];
									k_r     <= w_data_r[`CMD_K_MSB:`CMD_K_LSB];
									state_r <= ST_EXEC;
								end
								`OFS_ACC: begin
									if (w_strb_r[0]) acc_r <= w_data_r[7:0];
								end
								`OFS_STATUS: begin
									if (w_strb_r[0]) status_r <= w_data_r[7:0];
								end
								`OFS_PC: begin
									if (w_strb_r[0]) pc_r[7:0] <= w_data_r[7:0];
									if (w_strb_r[1]) pc_r[10:8] <= w_data_r[10:8];
								end
								`OFS_STACK: begin
									if (w_strb_r[0]) stack_r[7:0] <= w_data_r[7:0];
									if (w_strb_r[1]) stack_r[10:8] <= w_data_r[10:8];
								end
								`OFS_STATE: begin
									// Write one to clear the bad code flag
									if (w_strb_r[0] && w_data_r[`EX_BAD_BIT]) bad_op_r <= 1'b0;
								end
								default: begin
									state_r <= ST_IDLE;
								end
							endcase
						end
					end
				end
				ST_EXEC: begin
					state_r    <= ST_IDLE;
					last_cyc_r <= `CYC_SINGLE;
					pc_r       <= pc_inc;
					case (op_r)
						`OP_JUMP: begin
							pc_r[8:0]  <= k_r;
							pc_r[10:9] <= status_r[`ST_PAGE_MSB:`ST_PAGE_LSB];
							last_cyc_r <= `CYC_DOUBLE;
							state_r    <= ST_FLUSH;
						end
						`OP_OR_LIT: begin
							acc_r                 <= alu_res;
							status_r[`ST_ZERO_BIT] <= alu_zero;
						end
						`OP_OR_FILE, `OP_MOVE_FILE: begin
							if (dest_r) begin
								file_mem[fsel_r] <= alu_res;
							end else begin
								acc_r <= alu_res;
							end
							status_r[`ST_ZERO_BIT] <= alu_zero;
						end
						`OP_STORE: begin
							file_mem[fsel_r] <= acc_r;
						end
						`OP_LOAD_LIT: begin
							acc_r <= k_r[7:0];
						end
						`OP_LOAD_CFG: begin
							config_r <= acc_r;
						end
						`OP_RETURN: begin
							acc_r      <= k_r[7:0];
							pc_r       <= stack_r;
							last_cyc_r <= `CYC_DOUBLE;
							state_r    <= ST_FLUSH;
						end
						`OP_IDLE: begin
							last_cyc_r <= `CYC_SINGLE;
						end
						default: begin
							// Unknown codes behave as idle and are flagged
							bad_op_r <= 1'b1;
						end
					endcase
				end
				ST_FLUSH: begin
					// Discarded fetch slot: nothing changes
					state_r <= ST_IDLE;
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

endmodule // core_exec

// ==== hdl/core_exec_consts.vh ====
// Constants for the instruction execution core: register offsets,
// field positions, operation codes, reset values and cycle counts.
// Assumes an 8-bit byte address on the register bus, 32-bit data.
`ifndef CORE_EXEC_CONSTS_VH
`define CORE_EXEC_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CMD          8'h00
`define OFS_ACC          8'h04
`define OFS_STATUS       8'h08
`define OFS_PC           8'h0C
`define OFS_CONFIG       8'h10
`define OFS_STACK        8'h14
`define OFS_STATE        8'h18
`define FILE_WIN_BIT     7

// ----------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------
`define CMD_OP_MSB       3
`define CMD_OP_LSB       0
`define CMD_DEST_BIT     4
`define CMD_FILE_MSB     12
`define CMD_FILE_LSB     8
`define CMD_K_MSB        24
`define CMD_K_LSB        16

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define OP_IDLE          4'h0
`define OP_JUMP          4'h1
`define OP_OR_LIT        4'h2
`define OP_OR_FILE       4'h3
`define OP_STORE         4'h4
`define OP_MOVE_FILE     4'h5
`define OP_LOAD_LIT      4'h6
`define OP_LOAD_CFG      4'h7
`define OP_RETURN        4'h8

// ----------------------------------------------------------------
// Core status and execution state fields
// ----------------------------------------------------------------
`define ST_ZERO_BIT      2
`define ST_PAGE_MSB      6
`define ST_PAGE_LSB      5
`define EX_BUSY_BIT      0
`define EX_BAD_BIT       2
`define EX_CYC_MSB       5
`define EX_CYC_LSB       4

// ----------------------------------------------------------------
// Reset values, cycle counts, bus answers
// ----------------------------------------------------------------
`define RST_ACC          8'h00
`define RST_STATUS       8'h00
`define RST_PC           11'h000
`define RST_CONFIG       8'hFF
`define RST_STACK        11'h000
`define CYC_SINGLE       2'h1
`define CYC_DOUBLE       2'h2
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ==== hdl/result_unit.v ====
// Result path for the execution core: OR or pass-through of a byte,
// with the zero indication of the result.
// Assumes the caller zeroes operand a for a plain move.
`timescale 1ns/100ps

module result_unit #(
	parameter W = 8
) (
	input  wire [W-1:0] a,
	input  wire [W-1:0] b,
	output wire [W-1:0] result,
	output wire         zero
);

	// ----------------------------------------------------------------
	// Combine and test
	// ----------------------------------------------------------------
	// A move is an OR with zero, so one path serves both
	assign result = a | b;
	assign zero   = (result == {W{1'b0}});

endmodule // result_unit

// ==== verification/baseline_cpu_move_logic_branch_ops_tb_top.sv ====
// Self-checking bench: commands over AXI4-Lite, read-backs scoreboarded.
// Assumes the file_model shadow and the bound checker are compiled.
`timescale 1ns/100ps
`include "core_exec_consts.vh"

module baseline_cpu_move_logic_branch_ops_tb_top;
	reg         aclk = 1'b0, aresetn = 1'b0;
	reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	reg  [31:0] s_axi_wdata = 32'h0;
	reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	reg         s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [10:0] pc_out;
	wire [7:0]  config_out;
	integer     err_count = 0, checked = 0, cyc = 0, i;
	reg  [41:0] exp_q [$];
	reg  [41:0] e;
	reg  [9:0]  resp_q [$];
	reg  [9:0]  be;
	reg  [1:0]  bexp = `RESP_OKAY;
	reg  [7:0]  acc, st, k, v;
	reg  [10:0] pc, stk;
	reg  [4:0]  f;
	reg  [8:0]  k9;

	always #4 aclk = ~aclk;

	core_exec dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .pc_out, .config_out);
	file_model fm_u ();

	// ----------------------------------------
	// Bus tasks and scoreboard
	// ----------------------------------------
	task chk(input [7:0] nm, input [33:0] seen, input [33:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("[ERR] reg %h expected %h seen %h", nm, exp, seen);
			end
		end
	endtask

	// Address and data offered together, each dropped once taken
	task wr(input [7:0] a, input [31:0] d);
		reg aw_ok, w_ok;
		begin
			aw_ok = 1'b0;
			w_ok = 1'b0;
			resp_q.push_back({a, bexp});
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			while (!(aw_ok && w_ok)) begin
				@(posedge aclk);
				aw_ok = aw_ok | s_axi_awready;
				w_ok = w_ok | s_axi_wready;
				s_axi_awvalid <= !aw_ok;
				s_axi_wvalid <= !w_ok;
			end
			do @(posedge aclk); while (!s_axi_bvalid);
		end
	endtask

	task rd(input [7:0] a, input [33:0] ex);
		begin
			exp_q.push_back({a, ex});
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			do @(posedge aclk); while (!s_axi_arready);
			s_axi_arvalid <= 1'b0;
			do @(posedge aclk); while (!s_axi_rvalid);
		end
	endtask

	task op(input [3:0] c, input dd, input [4:0] ff, input [8:0] kk);
		begin
			wr(`OFS_CMD, {7'h0, kk, 3'h0, ff, 3'h0, dd, c});
			pc = pc + 11'h001;
		end
	endtask

	task zf(input [7:0] r);
		st[`ST_ZERO_BIT] = (r == 8'h00);
	endtask

	function [7:0] fa(input [4:0] x);
		fa = {1'b1, x, 2'b00};
	endfunction

	task tally_and_finish;
		begin
			if (err_count == 0 && checked > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask

	// Oldest note against each read answer and each write answer
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			e = exp_q.pop_front();
			chk(e[41:34], {s_axi_rresp, s_axi_rdata}, e[33:0]);
		end
		if (s_axi_bvalid && s_axi_bready) begin
			be = resp_q.pop_front();
			chk(be[9:2], {32'h0, s_axi_bresp}, {32'h0, be[1:0]});
		end
	end

	// Hang guard, far above the 150 or so cycles the run needs
	always @(posedge aclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_count = err_count + 1;
			tally_and_finish;
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		void'($urandom(32'h2BACED65));
		acc = 8'h00;
		pc = 11'h000;
		rd(`OFS_ACC, 34'h0);
		rd(`OFS_CONFIG, {26'h0, `RST_CONFIG});
		k = 8'($urandom);
		st = {1'b0, k[1:0], 5'h04};
		wr(`OFS_STATUS, {24'h0, st});
		// Literal load and store leave a set zero flag alone
		k = 8'($urandom) | 8'h01;
		op(`OP_LOAD_LIT, 1'b0, 5'h00, {1'b0, k});
		acc = k;
		rd(`OFS_ACC, {26'h0, acc});
		f = 5'($urandom);
		op(`OP_STORE, 1'b0, f, 9'h000);
		fm_u.put(f, acc);
		rd(fa(f), {26'h0, fm_u.get(f)});
		rd(`OFS_STATUS, {26'h0, st});
		// Literal OR, nonzero then zero result
		for (i = 0; i < 2; i = i + 1) begin
			op(`OP_LOAD_LIT, 1'b0, 5'h00, 9'h000);
			k = (i == 0) ? (8'($urandom) | 8'h80) : 8'h00;
			op(`OP_OR_LIT, 1'b0, 5'h00, {1'b0, k});
			acc = k;
			zf(acc);
			rd(`OFS_ACC, {26'h0, acc});
			rd(`OFS_STATUS, {26'h0, st});
		end
		// File OR to either destination
		k = 8'($urandom) | 8'h01;
		op(`OP_LOAD_LIT, 1'b0, 5'h00, {1'b0, k});
		acc = k;
		op(`OP_OR_FILE, 1'b1, f, 9'h000);
		v = acc | fm_u.get(f);
		fm_u.put(f, v);
		zf(v);
		rd(fa(f), {26'h0, v});
		rd(`OFS_ACC, {26'h0, acc});
		op(`OP_OR_FILE, 1'b0, f, 9'h000);
		acc = acc | fm_u.get(f);
		rd(`OFS_ACC, {26'h0, acc});
		// In-place move tests an untouched register for zero
		op(`OP_MOVE_FILE, 1'b1, ~f, 9'h000);
		zf(fm_u.get(~f));
		rd(`OFS_STATUS, {26'h0, st});
		op(`OP_MOVE_FILE, 1'b0, f, 9'h000);
		acc = fm_u.get(f);
		zf(acc);
		rd(`OFS_ACC, {26'h0, acc});
		rd(`OFS_STATUS, {26'h0, st});
		op(`OP_LOAD_CFG, 1'b0, 5'h00, 9'h000);
		rd(`OFS_CONFIG, {26'h0, acc});
		chk(`OFS_CONFIG, {26'h0, config_out}, {26'h0, acc});
		// Jump with page bits, then return from the stack top
		k9 = 9'($urandom);
		op(`OP_JUMP, 1'b0, 5'h00, k9);
		pc = {st[6:5], k9};
		rd(`OFS_PC, {23'h0, pc});
		rd(`OFS_STATE, 34'h20);
		rd(`OFS_STATUS, {26'h0, st});
		stk = 11'($urandom);
		wr(`OFS_STACK, {21'h0, stk});
		k = 8'($urandom);
		op(`OP_RETURN, 1'b0, 5'h00, {1'b0, k});
		pc = stk;
		rd(`OFS_PC, {23'h0, pc});
		rd(`OFS_ACC, {26'h0, k});
		rd(`OFS_STATUS, {26'h0, st});
		rd(`OFS_STATE, 34'h20);
		op(`OP_IDLE, 1'b0, 5'h00, 9'h000);
		rd(`OFS_PC, {23'h0, pc});
		rd(`OFS_STATE, 34'h10);
		rd(`OFS_ACC, {26'h0, k});
		rd(`OFS_STATUS, {26'h0, st});
		chk(`OFS_PC, {23'h0, pc_out}, {23'h0, pc});
		// Unknown code runs as idle and leaves a sticky flag
		op(4'hF, 1'b0, 5'h00, 9'h000);
		rd(`OFS_PC, {23'h0, pc});
		rd(`OFS_STATE, 34'h14);
		wr(`OFS_STATE, 32'h0000_0004);
		rd(`OFS_STATE, 34'h10);
		// Config is read only from the bus: the write is refused
		bexp = `RESP_SLVERR;
		wr(`OFS_CONFIG, 32'h0000_0000);
		bexp = `RESP_OKAY;
		rd(`OFS_CONFIG, {26'h0, acc});
		rd(8'h1C, {`RESP_SLVERR, 32'h0});
		repeat (4) @(posedge aclk);
		tally_and_finish;
	end
endmodule // baseline_cpu_move_logic_branch_ops_tb_top

// ==== verification/core_exec_asserts.sv ====
// Port-level checker for the execution core.
// Assumes it is bound to every core_exec instance.
`timescale 1ns/100ps
`include "core_exec_consts.vh"

module core_exec_asserts #(
	parameter FILE_DEPTH = 32
) (
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [7:0]  s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [10:0] pc_out,
	input wire [7:0]  config_out
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_rd_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_wr_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:4] s_axi_bvalid) else $error("write answer late");
	a_unmap_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h1C
		|=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
	a_resp_code: assert property (s_axi_bvalid |-> s_axi_bresp != 2'h1 && s_axi_bresp != 2'h3)
		else $error("bad write response code");
	// Config only moves as a command completes
	// The command answer is seen two samples before the copied config moves
	a_cfg_cause: assert property (!$stable(config_out) |-> $past(s_axi_bvalid, 2))
		else $error("config changed without command");
	a_pc_cause: assert property (!$stable(pc_out) |-> $past(s_axi_bvalid)
		|| $past(s_axi_bvalid, 2) || !$past(s_axi_awready)) else $error("counter moved idle");

	c_unmap: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h1C);
	c_pc: cover property (!$stable(pc_out));
	c_cfg: cover property (!$stable(config_out));
endmodule // core_exec_asserts

bind core_exec core_exec_asserts #(.FILE_DEPTH(FILE_DEPTH)) chk_u (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pc_out, .config_out);

// ==== verification/file_model.sv ====
// Behavioural shadow of the 32-byte file register window.
// Assumes the bench calls put/get in step with the commands it issues.
`timescale 1ns/100ps

module file_model;
	reg [7:0] mem [0:31];
	integer   j;

	// Cleared content, as after reset
	initial begin
		for (j = 0; j < 32; j = j + 1)
			mem[j] = 8'h00;
	end

	// Destination writes land here only when the file is chosen
	task put(input [4:0] a, input [7:0] v);
		mem[a] = v;
	endtask

	function [7:0] get(input [4:0] a);
		get = mem[a];
	endfunction
endmodule // file_model
